// ==== rtl/bit_band_pkg.sv ====
`default_nettype none
package bit_band_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] PERI_BASE       = 32'h4000_0000;
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
    localparam int          REGION_BITS     = 20;   // 1 MB bit-band region
    localparam int          ALIAS_BITS      = 25;   // 32 MB alias window
    localparam logic [31:0] SRAM_ALIAS_LAST = 32'h2203_ffff;
    localparam logic [31:0] PERI_ALIAS_LAST = 32'h43ff_ffff;
    localparam int          BIT_SHIFT       = 2;    // bit number x 4
    localparam int          BYTE_SHIFT      = 5;    // byte offset x 32

    // ------------------------------------------------------------
    // Access sizes
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Request carried between a master and a slave port
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;   // Instruction fetch when high
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // Response from a slave port
    typedef struct packed {
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } mem_rsp_t;

endpackage
`default_nettype wire

// ==== rtl/bit_band_alias_remapper.sv ====
// How it works
// [R1] One alias word selects exactly one target bit of the bit-band region.
// [R2] Bit-band regions are the lowest megabyte of SRAM and of peripheral space.
// [R3] The 256 KB SRAM alias window (up to 2203_FFFF) maps onto the first 8 KB of the SRAM bit region.
// [R4] The 32 MB peripheral alias window maps onto the 1 MB peripheral bit region.
// [R5] The remapped access uses the same size as the alias access.
// [R6] Direct SRAM bit-region accesses pass through as ordinary SRAM accesses.
// [R7] SRAM alias data accesses remap; instruction fetches pass through unchanged.
// [R8] Direct peripheral bit-region accesses pass through as ordinary accesses.
// [R9] Peripheral alias data accesses remap; instruction fetches are refused.
// [R10] An alias write is a read, one-bit modify, then write back.
// [R11] Alias offset equals byte offset times 32 plus bit number times 4.
// [R12] Alias address is window base plus offset; decode inverts it.
// [R13] Bit number 0 to 7 comes from the word within each 32-byte group.
// [R14] Write data bit 0 sets or clears the targeted bit.
// [R15] Write data bits 31 down to 1 are ignored.
// [R16] Alias read returns 0 or 1 with all upper bits zero.
// [R17] Data is little-endian: lowest address holds the least significant byte.
// [R18] Read and write halves of the modify go back to back, uninterrupted.
`default_nettype none
module bit_band_alias_remapper
    import bit_band_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     reset_n,
    input  wire mem_req_t cpu_req,
    output var mem_rsp_t  cpu_rsp,
    output var mem_req_t  mem_req,
    input  wire mem_rsp_t mem_rsp,
    output logic          mem_lock
);

    // ------------------------------------------------------------
    // Decode of the incoming address
    // ------------------------------------------------------------
    typedef enum {
        ST_IDLE,
        ST_PASS,
        ST_ALIAS_RD,
        ST_ALIAS_WR,
        ST_DONE
    } state_t;

    state_t      state_r;
    mem_req_t    hold_r;
    logic        is_sram_alias;
    logic        is_peri_alias;
    logic        is_alias;
    logic [31:0] target_addr;
    logic [2:0]  target_bit;

    // Window checks on the full address against each window's base and last address
    assign is_sram_alias = (cpu_req.addr >= SRAM_ALIAS_BASE)
                        && (cpu_req.addr <= SRAM_ALIAS_LAST);      // [R3] [R7]
    assign is_peri_alias = (cpu_req.addr >= PERI_ALIAS_BASE)
                        && (cpu_req.addr <= PERI_ALIAS_LAST);      // [R4] [R9]
    assign is_alias      = (is_sram_alias && !cpu_req.fetch)
                        || is_peri_alias;

    // Invert the alias formula: offset/32 is the byte, (offset/4)%8 the bit
    always_comb begin
        logic [31:0] ofs;
        ofs         = 32'h0;
        target_addr = 32'h0;
        ofs = cpu_req.addr - (is_sram_alias ? SRAM_ALIAS_BASE : PERI_ALIAS_BASE); // [R12]
        target_bit  = ofs[BIT_SHIFT +: 3];                          // [R13]
        target_addr = (is_sram_alias ? SRAM_BASE : PERI_BASE)       // [R2]
                    | {12'h0, ofs[BYTE_SHIFT +: REGION_BITS]};      // [R1] [R11]
    end

    // ------------------------------------------------------------
    // Held alias context
    // ------------------------------------------------------------
    logic [2:0]  bit_r;
    logic [1:0]  lane_r;
    logic        wbit_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_r  <= 3'h0;
            lane_r <= 2'h0;
            wbit_r <= 1'b0;
        end else if (state_r == ST_IDLE && cpu_req.valid) begin
            bit_r  <= target_bit;
            lane_r <= target_addr[1:0];
            wbit_r <= cpu_req.wdata[0];                             // [R14] [R15]
        end
    end

    // ------------------------------------------------------------
    // Data lane helpers
    // ------------------------------------------------------------
    // Bit position of the targeted bit inside the little-endian data word
    logic [4:0] bitpos;
    assign bitpos = {lane_r, bit_r};                                // [R17]

    logic [31:0] rd_word;
    logic [31:0] wr_word;
    assign rd_word = mem_rsp.rdata;
    always_comb begin
        wr_word = rd_word;
        wr_word[bitpos] = wbit_r;                                   // [R10] [R14]
    end

    // ------------------------------------------------------------
    // Sequencer and outgoing request
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r  <= ST_IDLE;
            hold_r   <= '0;
            mem_req  <= '0;
            mem_lock <= 1'b0;
            cpu_rsp  <= '0;
        end else begin
            cpu_rsp <= '0;
            case (state_r)
                ST_IDLE: begin
                    if (cpu_req.valid) begin
                        hold_r <= cpu_req;
                        if (is_peri_alias && cpu_req.fetch) begin
                            cpu_rsp.done <= 1'b1;                   // [R9]
                            cpu_rsp.err  <= 1'b1;
                            state_r      <= ST_DONE;
                        end else if (is_alias) begin
                            mem_req.valid <= 1'b1;
                            mem_req.write <= 1'b0;
                            mem_req.fetch <= 1'b0;
                            mem_req.size  <= cpu_req.size;          // [R5]
                            mem_req.addr  <= target_addr;           // [R3] [R4]
                            mem_req.wdata <= 32'h0;
                            mem_lock      <= cpu_req.write;         // [R18]
                            state_r       <= ST_ALIAS_RD;
                        end else begin
                            mem_req <= cpu_req;                     // [R6] [R7] [R8]
                            state_r <= ST_PASS;
                        end
                    end
                end
                ST_PASS: begin
                    mem_req.valid <= 1'b0;
                    if (mem_rsp.done) begin
                        cpu_rsp <= mem_rsp;
                        state_r <= ST_DONE;
                    end
                end
                ST_ALIAS_RD: begin
                    mem_req.valid <= 1'b0;
                    if (mem_rsp.done) begin
                        if (hold_r.write && !mem_rsp.err) begin
                            mem_req.valid <= 1'b1;                  // [R10] [R18]
                            mem_req.write <= 1'b1;
                            mem_req.wdata <= wr_word;
                            state_r       <= ST_ALIAS_WR;
                        end else begin
                            mem_lock      <= 1'b0;
                            cpu_rsp.done  <= 1'b1;
                            cpu_rsp.err   <= mem_rsp.err;
                            cpu_rsp.rdata <= {31'h0, rd_word[bitpos]}; // [R16]
                            state_r       <= ST_DONE;
                        end
                    end
                end
                ST_ALIAS_WR: begin
                    mem_req.valid <= 1'b0;
                    if (mem_rsp.done) begin
                        mem_lock     <= 1'b0;
                        cpu_rsp.done <= 1'b1;
                        cpu_rsp.err  <= mem_rsp.err;
                        state_r      <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // One idle cycle so the master drops its request
                    mem_req <= '0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== dv/bit_band_asserts.sv ====
`default_nettype none
module bit_band_asserts
    import bit_band_pkg::*;
(
    input wire logic     sys_clk,
    input wire logic     reset_n,
    input wire mem_req_t cpu_req,
    input wire mem_rsp_t cpu_rsp,
    input wire mem_req_t mem_req,
    input wire mem_rsp_t mem_rsp,
    input wire logic     mem_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        peri_hit;
    logic        alias_hit;
    logic [31:0] tgt;
    logic [4:0]  bpos;
    logic [31:0] last_rd;
    // Decode the held core request into target byte and bit
    assign peri_hit  = cpu_req.addr >= PERI_ALIAS_BASE && cpu_req.addr <= PERI_ALIAS_LAST;
    assign alias_hit = !cpu_req.fetch && (peri_hit
        || (cpu_req.addr >= SRAM_ALIAS_BASE && cpu_req.addr <= SRAM_ALIAS_LAST));
    assign tgt  = (peri_hit ? PERI_BASE : SRAM_BASE) | {12'h0, cpu_req.addr[24:5]};
    assign bpos = {tgt[1:0], cpu_req.addr[4:2]};
    // Last word that memory returned
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_rd <= 32'h0;
        end else if (mem_rsp.done) begin
            last_rd <= mem_rsp.rdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    fetch_refused_a: assert property ($rose(cpu_req.valid) && cpu_req.fetch && peri_hit
        |=> cpu_rsp.done && cpu_rsp.err && !mem_req.valid) else $error("fetch not refused");
    size_kept_a: assert property (mem_req.valid |-> mem_req.size == cpu_req.size)
        else $error("size changed");
    target_addr_a: assert property (mem_req.valid && alias_hit |-> mem_req.addr == tgt)
        else $error("bad target address");
    pass_thru_a: assert property (mem_req.valid && !alias_hit |-> mem_req.addr == cpu_req.addr
        && mem_req.write == cpu_req.write) else $error("pass-through altered");
    read_first_a: assert property ($rose(cpu_req.valid) && alias_hit && cpu_req.write
        |=> mem_req.valid && !mem_req.write && mem_lock) else $error("no read first");
    write_back_a: assert property (mem_req.valid && mem_req.write && alias_hit |-> mem_lock
        && mem_req.wdata == ((last_rd & ~(32'h1 << bpos)) | ({31'h0, cpu_req.wdata[0]} << bpos)))
        else $error("bad write back");
    back_to_back_a: assert property (mem_rsp.done && mem_lock && !mem_req.write && !mem_rsp.err
        |=> mem_req.valid && mem_req.write) else $error("write back delayed");
    bit_read_a: assert property (cpu_rsp.done && !cpu_rsp.err && alias_hit && !cpu_req.write
        |-> cpu_rsp.rdata == {31'h0, last_rd[bpos]}) else $error("bad alias read");
    answer_time_a: assert property (mem_rsp.done && !mem_lock |=> cpu_rsp.done)
        else $error("late answer");
    cover property ($rose(mem_lock));
    cover property (cpu_rsp.done && cpu_rsp.err);
    cover property (cpu_rsp.done && alias_hit && !cpu_req.write);
endmodule
bind bit_band_alias_remapper bit_band_asserts i_bit_band_asserts (.sys_clk, .reset_n,
    .cpu_req, .cpu_rsp, .mem_req, .mem_rsp, .mem_lock);
`default_nettype wire

// ==== dv/bit_band_mem_model.sv ====
`default_nettype none
module bit_band_mem_model
    import bit_band_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire mem_req_t   mem_req,
    input  wire logic [1:0] lat,
    output var mem_rsp_t    mem_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [logic [29:0]];
    mem_req_t    req_r;
    logic [2:0]  cnt_r;
    logic        busy_r;
    logic [31:0] word;
    logic [31:0] lane;
    // Answer after lat idle cycles; unwritten words read as their address
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r = 1'b0;
            mem_rsp <= '0;
        end else begin
            mem_rsp <= {2'h0, ~mem_rsp.rdata};  // Idle bus toggles
            if (mem_req.valid) begin
                req_r = mem_req;
                cnt_r = {1'b0, lat};
                busy_r = 1'b1;
            end else if (busy_r && cnt_r != 3'h0) begin
                cnt_r = cnt_r - 3'h1;
            end else if (busy_r) begin
                busy_r = 1'b0;
                word = mem.exists(req_r.addr[31:2]) ? mem[req_r.addr[31:2]]
                    : {req_r.addr[31:2], 2'h0};  // Unwritten word reads as its aligned address
                lane = req_r.size == SIZE_WORD ? 32'hffff_ffff : req_r.size == SIZE_HALF
                    ? 32'hffff << (req_r.addr[1] * 16) : 32'hff << (req_r.addr[1:0] * 8);
                if (req_r.write) mem[req_r.addr[31:2]] = (word & ~lane) | (req_r.wdata & lane);
                mem_rsp <= {2'h2, word};
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/bit_band_alias_remapper_tb.sv ====
`default_nettype none
module bit_band_alias_remapper_tb;
    import bit_band_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk;
    logic        reset_n;
    mem_req_t    cpu_req;
    mem_rsp_t    cpu_rsp;
    mem_req_t    mem_req;
    mem_rsp_t    mem_rsp;
    logic        mem_lock;
    logic [1:0]  lat;
    logic [31:0] rd;
    logic        er;
    int          n_fail;
    int          num_checks;
    bit_band_alias_remapper i_bit_band_alias_remapper (.sys_clk, .reset_n, .cpu_req,
        .cpu_rsp, .mem_req, .mem_rsp, .mem_lock);
    bit_band_mem_model i_bit_band_mem_model (.sys_clk, .reset_n, .mem_req, .lat, .mem_rsp);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One core access, held until done is seen at a falling edge, released at the next rising edge
    task automatic acc(input logic wr, fe, input logic [1:0] sz, input logic [31:0] a, wd);
        int i;
        @(posedge sys_clk);
        cpu_req <= '{1'b1, wr, fe, sz, a, wd};
        for (i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            if (cpu_rsp.done === 1'b1) break;
        end
        if (i == 40) begin
            n_fail++;
            tally_and_finish;
        end
        rd = cpu_rsp.rdata;
        er = cpu_rsp.err;
        @(posedge sys_clk);
        cpu_req <= '0;
    endtask
    task automatic sram_bits;
        acc(1'b1, 1'b0, SIZE_WORD, 32'h2200_001c, 32'hff);
        acc(1'b0, 1'b0, SIZE_WORD, 32'h2000_0000, 32'h0);
        chk("sram set", 32'h2000_0080, rd);
        acc(1'b1, 1'b0, SIZE_WORD, 32'h2200_001c, 32'h0e);
        acc(1'b0, 1'b0, SIZE_WORD, 32'h2000_0000, 32'h0);
        chk("sram clear", 32'h2000_0000, rd);
    endtask
    task automatic sram_top;
        lat <= 2'h2;
        acc(1'b1, 1'b0, SIZE_BYTE, 32'h2203_fffc, 32'h1);
        acc(1'b0, 1'b0, SIZE_BYTE, 32'h2203_fffc, 32'h0);
        chk("alias read", 32'h1, rd);
        acc(1'b0, 1'b0, SIZE_WORD, 32'h2000_1ffc, 32'h0);
        chk("top byte", 32'ha000_1ffc, rd);
    endtask
    task automatic peri_bits;
        lat <= 2'h3;
        acc(1'b1, 1'b0, SIZE_HALF, 32'h43ff_ffe0, 32'h1);
        acc(1'b0, 1'b0, SIZE_WORD, 32'h43ff_ffe4, 32'h0);
        chk("peri bit1", 32'h0, rd);
        acc(1'b0, 1'b0, SIZE_WORD, 32'h400f_fffc, 32'h0);
        chk("peri word", 32'h410f_fffc, rd);
    endtask
    task automatic fetches;
        lat <= 2'h0;
        acc(1'b0, 1'b1, SIZE_WORD, 32'h4200_0000, 32'h0);
        chk("peri fetch err", 32'h1, {31'h0, er});
        acc(1'b0, 1'b1, SIZE_WORD, 32'h2200_0000, 32'h0);
        chk("sram fetch", 32'h2200_0000, rd);
    endtask
    initial begin
        n_fail = 0;
        num_checks = 0;
        lat = 2'h0;
        cpu_req = '0;
        reset_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        sram_bits;
        sram_top;
        peri_bits;
        fetches;
        tally_and_finish;
    end
endmodule
`default_nettype wire
